// file: src/dcs_defines.svh
// register map, field positions, reset values and address steps of the dma channel register block
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH

`define DCS_NUM_CH 8
// byte address = channel * 0x20 + register index * 4; status block at 0x100
`define DCS_ADDR_HI_ZERO 3'h0
`define DCS_REG_CONTROL 3'h0
`define DCS_REG_REQUEST 3'h1
`define DCS_REG_PRIMARY 3'h2
`define DCS_REG_SECONDARY 3'h3
`define DCS_REG_PERIPH 3'h4
`define DCS_REG_COUNT 3'h5
`define DCS_ST_LAST_ADDR 3'h0
`define DCS_ST_COLLISION 3'h1
`define DCS_ST_ACTIVITY 3'h2

`define DCS_CTRL_ON_BIT 15
`define DCS_CTRL_BYTE_BIT 14
`define DCS_CTRL_DIR_BIT 13
`define DCS_CTRL_HALF_BIT 12
`define DCS_CTRL_NULL_WRITE_MODE_BIT 11
`define DCS_CTRL_ADDRESSING_SELECT_LO 4
`define DCS_CTRL_MODE_LO 0
`define DCS_REQ_FORCE_BIT 15

`define DCS_ADDRESSING_SELECT_POSTINC 2'h0
`define DCS_MODE_ONESHOT_BIT 0
`define DCS_MODE_PINGPONG_BIT 1
`define DCS_LAST_CH_RESET 4'hF
`define DCS_RESET_WORD 16'h0000
`define DCS_STEP_BYTE 16'h0001
`define DCS_STEP_WORD 16'h0002

`endif

// file: src/dcs_pkg.sv
// types of the dma channel register block
package dcs_pkg;

    typedef enum logic [0:0] {DCS_IDLE, DCS_BUSY} dcs_fsm_t;

    typedef struct packed {
        logic on;
        logic byte_mode;
        logic to_periph;
        logic half_irq;
        logic null_write_mode;
        logic [1:0] addressing_select;
        logic [1:0] op_mode;
        logic force_req;
        logic [6:0] request_source_select;
        logic [15:0] primary_start_offset;
        logic [15:0] secondary_start_offset;
        logic [15:0] periph_addr;
        logic [9:0] xfer_count;
        logic [15:0] cur_addr;
        logic [9:0] remain;
        logic pend;
        logic pingpong_buffer_flag;
        logic sram_write_collision_flag;
        logic peripheral_write_collision_flag;
    } dcs_ch_t;

    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic [15:0] sram_addr;
        logic [15:0] periph_addr;
        logic to_periph;
        logic byte_mode;
        logic null_write;
    } dcs_xfer_t;

    typedef struct packed {
        dcs_ch_t [7:0] ch;
        logic [15:0] last_sram_address;
        logic [3:0] last_active_channel;
        dcs_fsm_t fsm;
        logic [2:0] cur_ch;
        dcs_xfer_t xfer;
        logic [7:0] ch_irq;
        logic bus_pend;
        logic bus_write;
        logic [11:0] bus_addr;
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
    } dcs_state_t;

endpackage

// file: src/dcs_regs.sv
// dma channel configuration and status registers with a single-transfer engine, ahb-lite slave
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "dcs_defines.svh"

// Behaviour
// - read-only last sram access address register
// - last address clears to zero on reset
// - per-channel sram and peripheral collision flags
// - last channel and ping-pong flags readable
// - channel runs only while enable bit set
// - size bit: one byte, zero word
// - direction bit: set sram to peripheral
// - half bit picks half or full interrupt
// - null write to peripheral when direction clear
// - addressing field: postinc, fixed, peripheral, reserved
// - continuous or one-shot, optional ping-pong
// - unimplemented bits ignore writes, read zero
// - force bit starts one manual transfer
// - force ignores clear, hardware clears after
// - seven-bit request source select field
// - sixteen-bit primary start offset per channel
// - sixteen-bit secondary start offset per channel
// - sixteen-bit peripheral address per channel
// - last channel resets to 1111, 0..7 named
// - ping-pong flag one while secondary used
// - count plus one transfers per block
module dcs_regs
    import dcs_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    input wire logic [127:0] REQ_VEC,
    input wire logic XFER_DONE,
    input wire logic SRAM_WCOL,
    input wire logic PERIPH_WCOL,
    output dcs_xfer_t XFER,
    output logic [7:0] CH_IRQ
);

    dcs_state_t s_q;
    dcs_state_t s_d;
    logic [7:0] req_hit;

    // each channel watches the one request line its source field names
    genvar g;
    generate
        for (g = 0; g < `DCS_NUM_CH; g++) begin : g_req
            assign req_hit[g] = REQ_VEC[s_q.ch[g].request_source_select];
        end
    endgenerate

    // read-back words are built bit by bit from the field positions, so unused bits stay zero
    function automatic logic [15:0] ctrl_word(input dcs_ch_t ch);
        logic [15:0] v;
        v = 16'h0000;
        v[`DCS_CTRL_ON_BIT] = ch.on;
        v[`DCS_CTRL_BYTE_BIT] = ch.byte_mode;
        v[`DCS_CTRL_DIR_BIT] = ch.to_periph;
        v[`DCS_CTRL_HALF_BIT] = ch.half_irq;
        v[`DCS_CTRL_NULL_WRITE_MODE_BIT] = ch.null_write_mode;
        v[`DCS_CTRL_ADDRESSING_SELECT_LO +: 2] = ch.addressing_select;
        v[`DCS_CTRL_MODE_LO +: 2] = ch.op_mode;
        return v;
    endfunction

    function automatic logic [15:0] req_word(input dcs_ch_t ch);
        logic [15:0] v;
        v = 16'h0000;
        v[`DCS_REQ_FORCE_BIT] = ch.force_req;
        v[6:0] = ch.request_source_select;
        return v;
    endfunction

    always_comb begin
        dcs_ch_t c;
        logic found;
        logic [2:0] pick;
        logic [2:0] k;
        logic [2:0] ci;
        logic [2:0] ri;
        logic [15:0] w;
        logic [15:0] rd;
        logic [15:0] step;
        logic [10:0] done_n;
        logic [10:0] half_n;
        logic mapped;
        logic new_pp;
        logic [7:0] xcol_set;
        logic [7:0] pcol_set;
        logic [7:0] xcol_v;
        logic [7:0] pcol_v;
        logic [7:0] pp_v;
        c = '0;
        found = 1'b0;
        pick = 3'h0;
        k = 3'h0;
        ci = 3'h0;
        ri = 3'h0;
        w = 16'h0000;
        rd = 16'h0000;
        step = 16'h0000;
        done_n = 11'h000;
        half_n = 11'h000;
        mapped = 1'b0;
        new_pp = 1'b0;
        xcol_set = 8'h00;
        pcol_set = 8'h00;
        xcol_v = 8'h00;
        pcol_v = 8'h00;
        pp_v = 8'h00;
        s_d = s_q;
        s_d.ch_irq = 8'h00;

        // transfer engine: one element in flight, lowest channel number first
        case (s_q.fsm)
            DCS_IDLE: begin
                for (int i = `DCS_NUM_CH - 1; i >= 0; i--) begin
                    if (s_q.ch[i].on && (s_q.ch[i].force_req || s_q.ch[i].pend)) begin
                        found = 1'b1;
                        pick = 3'(i);
                    end
                end
                if (found) begin
                    c = s_q.ch[pick];
                    s_d.fsm = DCS_BUSY;
                    s_d.cur_ch = pick;
                    s_d.xfer.valid = 1'b1;
                    s_d.xfer.chan = pick;
                    s_d.xfer.sram_addr = c.cur_addr;
                    s_d.xfer.periph_addr = c.periph_addr;
                    s_d.xfer.to_periph = c.to_periph;
                    s_d.xfer.byte_mode = c.byte_mode;
                    s_d.xfer.null_write = c.null_write_mode & ~c.to_periph;
                    if (!c.force_req) begin
                        s_d.ch[pick].pend = 1'b0;
                    end
                end
            end
            DCS_BUSY: begin
                if (XFER_DONE) begin
                    k = s_q.cur_ch;
                    c = s_q.ch[k];
                    s_d.fsm = DCS_IDLE;
                    s_d.xfer.valid = 1'b0;
                    s_d.last_sram_address = c.cur_addr;
                    s_d.last_active_channel = {1'b0, k};
                    xcol_set[k] = SRAM_WCOL;
                    pcol_set[k] = PERIPH_WCOL;
                    s_d.ch[k].force_req = 1'b0;
                    step = c.byte_mode ? `DCS_STEP_BYTE : `DCS_STEP_WORD;
                    // fixed and peripheral-indirect modes keep the offset; the reserved code acts as fixed
                    if (c.addressing_select == `DCS_ADDRESSING_SELECT_POSTINC) begin
                        s_d.ch[k].cur_addr = c.cur_addr + step;
                    end
                    done_n = 11'({1'b0, c.xfer_count} - {1'b0, c.remain}) + 11'h001;
                    half_n = 11'(({1'b0, c.xfer_count} + 11'h001) >> 1);
                    if (c.half_irq && done_n == half_n) begin
                        s_d.ch_irq[k] = 1'b1;
                    end
                    if (c.remain == 10'h000) begin
                        s_d.ch_irq[k] = ~c.half_irq;
                        new_pp = c.pingpong_buffer_flag;
                        if (c.op_mode[`DCS_MODE_PINGPONG_BIT]) begin
                            new_pp = ~c.pingpong_buffer_flag;
                        end
                        s_d.ch[k].pingpong_buffer_flag = new_pp;
                        s_d.ch[k].cur_addr = new_pp ? c.secondary_start_offset : c.primary_start_offset;
                        s_d.ch[k].remain = c.xfer_count;
                        // one-shot ping-pong stops only after the second buffer has been moved
                        if (c.op_mode[`DCS_MODE_ONESHOT_BIT] &&
                            (!c.op_mode[`DCS_MODE_PINGPONG_BIT] || c.pingpong_buffer_flag)) begin
                            s_d.ch[k].on = 1'b0;
                        end
                    end else begin
                        s_d.ch[k].remain = c.remain - 10'h001;
                    end
                end
            end
            default: begin
                s_d.fsm = DCS_IDLE;
                s_d.xfer.valid = 1'b0;
            end
        endcase

        // ahb-lite slave: one wait state so read data and hreadyout both come from flops
        if (s_q.bus_pend) begin
            s_d.bus_pend = 1'b0;
            s_d.hready = 1'b1;
            ci = s_q.bus_addr[7:5];
            ri = s_q.bus_addr[4:2];
            w = HWDATA[15:0];
            for (int i = 0; i < `DCS_NUM_CH; i++) begin
                xcol_v[i] = s_q.ch[i].sram_write_collision_flag;
                pcol_v[i] = s_q.ch[i].peripheral_write_collision_flag;
                pp_v[i] = s_q.ch[i].pingpong_buffer_flag;
            end
            c = s_q.ch[ci];
            if (s_q.bus_addr[11:9] != `DCS_ADDR_HI_ZERO) begin
                mapped = 1'b0;
            end else if (!s_q.bus_addr[8]) begin
                mapped = (ri <= `DCS_REG_COUNT);
                case (ri)
                    `DCS_REG_CONTROL: rd = ctrl_word(c);
                    `DCS_REG_REQUEST: rd = req_word(c);
                    `DCS_REG_PRIMARY: rd = c.primary_start_offset;
                    `DCS_REG_SECONDARY: rd = c.secondary_start_offset;
                    `DCS_REG_PERIPH: rd = c.periph_addr;
                    `DCS_REG_COUNT: rd = {6'h00, c.xfer_count};
                    default: rd = 16'h0000;
                endcase
            end else begin
                mapped = (ci == 3'h0) && (ri <= `DCS_ST_ACTIVITY);
                case (ri)
                    `DCS_ST_LAST_ADDR: rd = s_q.last_sram_address;
                    `DCS_ST_COLLISION: rd = {pcol_v, xcol_v};
                    `DCS_ST_ACTIVITY: rd = {4'h0, s_q.last_active_channel, pp_v};
                    default: rd = 16'h0000;
                endcase
            end
            s_d.hrdata = (mapped && !s_q.bus_write) ? {16'h0000, rd} : 32'h0000_0000;
            // status registers are read-only; unmapped writes are dropped
            if (s_q.bus_write && mapped && !s_q.bus_addr[8]) begin
                case (ri)
                    `DCS_REG_CONTROL: begin
                        s_d.ch[ci].on = w[`DCS_CTRL_ON_BIT];
                        s_d.ch[ci].byte_mode = w[`DCS_CTRL_BYTE_BIT];
                        s_d.ch[ci].to_periph = w[`DCS_CTRL_DIR_BIT];
                        s_d.ch[ci].half_irq = w[`DCS_CTRL_HALF_BIT];
                        s_d.ch[ci].null_write_mode = w[`DCS_CTRL_NULL_WRITE_MODE_BIT];
                        s_d.ch[ci].addressing_select = w[`DCS_CTRL_ADDRESSING_SELECT_LO +: 2];
                        s_d.ch[ci].op_mode = w[`DCS_CTRL_MODE_LO +: 2];
                        if (w[`DCS_CTRL_ON_BIT] && !c.on) begin
                            s_d.ch[ci].cur_addr = c.primary_start_offset;
                            s_d.ch[ci].remain = c.xfer_count;
                            s_d.ch[ci].pingpong_buffer_flag = 1'b0;
                            s_d.ch[ci].pend = 1'b0;
                        end
                        if (!w[`DCS_CTRL_ON_BIT]) begin
                            s_d.ch[ci].sram_write_collision_flag = 1'b0;
                            s_d.ch[ci].peripheral_write_collision_flag = 1'b0;
                        end
                    end
                    `DCS_REG_REQUEST: begin
                        s_d.ch[ci].request_source_select = w[6:0];
                        if (w[`DCS_REQ_FORCE_BIT]) begin
                            s_d.ch[ci].force_req = 1'b1;
                        end
                    end
                    `DCS_REG_PRIMARY: s_d.ch[ci].primary_start_offset = w;
                    `DCS_REG_SECONDARY: s_d.ch[ci].secondary_start_offset = w;
                    `DCS_REG_PERIPH: s_d.ch[ci].periph_addr = w;
                    `DCS_REG_COUNT: s_d.ch[ci].xfer_count = w[9:0];
                    default: s_d.hresp = 1'b0;
                endcase
            end
        end else if (HSEL && HTRANS[1] && HREADY) begin
            s_d.bus_pend = 1'b1;
            s_d.bus_write = HWRITE;
            s_d.bus_addr = HADDR[11:0];
            s_d.hready = 1'b0;
        end

        // hardware sets are applied last so they win over a same-cycle clear
        for (int i = 0; i < `DCS_NUM_CH; i++) begin
            if (s_d.ch[i].on && req_hit[i]) begin
                s_d.ch[i].pend = 1'b1;
            end
            if (xcol_set[i]) begin
                s_d.ch[i].sram_write_collision_flag = 1'b1;
            end
            if (pcol_set[i]) begin
                s_d.ch[i].peripheral_write_collision_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            s_q <= '0;
            s_q.last_sram_address <= `DCS_RESET_WORD;
            s_q.last_active_channel <= `DCS_LAST_CH_RESET;
            s_q.fsm <= DCS_IDLE;
            s_q.hready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign HREADYOUT = s_q.hready;
    assign HRESP = s_q.hresp;
    assign HRDATA = s_q.hrdata;
    assign XFER = s_q.xfer;
    assign CH_IRQ = s_q.ch_irq;

endmodule

// file: tb/dcs_regs_properties.sv
// concurrent checks on the ports of the dma channel register block
`timescale 1ns/1ps
module dcs_regs_properties
    import dcs_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [31:0] HRDATA,
    input wire logic XFER_DONE,
    input wire dcs_xfer_t XFER,
    input wire logic [7:0] CH_IRQ
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);

    a_wait_one: assert property (HSEL && HTRANS[1] && HREADY |=> !HREADYOUT ##1 HREADYOUT)
        else $error("slave did not insert exactly one wait state");
    a_resp_okay: assert property (HRESP == 1'b0)
        else $error("error response seen");
    a_rdata_high: assert property (HREADYOUT |-> HRDATA[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_xfer_stable: assert property (XFER.valid && !XFER_DONE |=> XFER.valid && $stable(XFER))
        else $error("transfer dropped or changed before done");
    a_xfer_ends: assert property (XFER.valid && XFER_DONE |=> !XFER.valid)
        else $error("transfer did not end after done");
    a_null_dir: assert property (XFER.valid |-> !(XFER.null_write && XFER.to_periph))
        else $error("null write while reading sram");
    a_irq_cause: assert property (CH_IRQ != 8'h00 |-> $past(XFER.valid) && $past(XFER_DONE)
        && CH_IRQ == (8'h01 << $past(XFER.chan)))
        else $error("channel pulse without a finished element");
    a_reset_idle: assert property ($fell(RESET) |-> HREADYOUT && !XFER.valid && CH_IRQ == 8'h00)
        else $error("block not idle after reset");
endmodule

// file: tb/dcs_far_end.sv
// far-side model: dma bus acknowledge and write-collision lines
`timescale 1ns/1ps
module dcs_far_end
    import dcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire dcs_xfer_t xfer,
    input wire logic [3:0] lat,
    input wire logic sram_hit,
    input wire logic periph_hit,
    output logic done,
    output logic sram_wcol,
    output logic periph_wcol
);
    logic [3:0] wait_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            wait_q <= 4'h0;
        else if (!xfer.valid || done)
            wait_q <= 4'h0;
        else
            wait_q <= wait_q + 4'h1;
    end
    // each acknowledge closes one element only
    assign done = xfer.valid && (wait_q == lat);
    // collision lines only count with done, so outside it they show the opposite level
    assign sram_wcol = done ? sram_hit : ~sram_hit;
    assign periph_wcol = done ? periph_hit : ~periph_hit;
endmodule

// file: tb/dcs_regs_tb.sv
// self-checking bench for the dma channel register block
`timescale 1ns/1ps
module dcs_regs_tb
    import dcs_pkg::*;
;
    typedef struct {logic [11:0] a; logic [15:0] w; logic [15:0] e;} dcs_row_t;
    logic REF_CLK, RESET, HSEL, HWRITE, HREADYOUT, HRESP, XFER_DONE, SRAM_WCOL, PERIPH_WCOL;
    logic s_hit, p_hit, rdy_s, vld_s;
    logic [31:0] HADDR, HWDATA, HRDATA, rd_v, hrd_s;
    logic [1:0] HTRANS;
    logic [127:0] REQ_VEC;
    logic [7:0] CH_IRQ;
    logic [3:0] lat;
    dcs_xfer_t XFER;
    dcs_xfer_t xq[$];
    dcs_xfer_t eq[$];
    int miscompares, comparisons, irq_n;
    dcs_row_t rows[10] = '{'{12'h020, 16'h7FFF, 16'h7833}, '{12'h024, 16'h7FFF, 16'h007F},
        '{12'h048, 16'hA5C3, 16'hA5C3}, '{12'h06C, 16'h5A3C, 16'h5A3C}, '{12'h0F0, 16'hFFFF, 16'hFFFF},
        '{12'h0F4, 16'hFFFF, 16'h03FF}, '{12'h100, 16'h1234, 16'h0000}, '{12'h104, 16'hFFFF, 16'h0000},
        '{12'h108, 16'hFFFF, 16'h0F00}, '{12'h1FC, 16'hFFFF, 16'h0000}};

    dcs_regs dut_u (.REF_CLK(REF_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .HRDATA(HRDATA), .REQ_VEC(REQ_VEC), .XFER_DONE(XFER_DONE), .SRAM_WCOL(SRAM_WCOL),
        .PERIPH_WCOL(PERIPH_WCOL), .XFER(XFER), .CH_IRQ(CH_IRQ));
    dcs_far_end far_u (.clk(REF_CLK), .rst(RESET), .xfer(XFER), .lat(lat), .sram_hit(s_hit),
        .periph_hit(p_hit), .done(XFER_DONE), .sram_wcol(SRAM_WCOL), .periph_wcol(PERIPH_WCOL));

    initial begin
        REF_CLK = 1'b0;
        forever #2.5 REF_CLK = ~REF_CLK;
    end
    // mid-cycle samples give the master what stood before each edge, free of edge races
    always @(negedge REF_CLK) begin
        rdy_s <= HREADYOUT;
        hrd_s <= HRDATA;
        vld_s <= XFER.valid;
        if (XFER.valid && !vld_s) xq.push_back(XFER);
        if (CH_IRQ != 8'h00) irq_n++;
    end

    task automatic chk(input string what, input logic [38:0] exp, input logic [38:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] wd);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR <= {20'h0_0000, a};
        @(posedge REF_CLK);
        while (!rdy_s) @(posedge REF_CLK);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= {16'h0000, wd};
        @(posedge REF_CLK);
        while (!rdy_s) @(posedge REF_CLK);
        rd_v = hrd_s;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk($sformatf("register %h", a), 39'({16'h0000, e}), 39'(rd_v));
    endtask
    task automatic wait_x(input int n);
        for (int i = 0; i < 400 && xq.size() < n; i++) @(posedge REF_CLK);
        // room for the last element to finish at the slowest model latency
        repeat (8) @(posedge REF_CLK);
    endtask
    task automatic results;
        if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge REF_CLK);
        miscompares++;
        results();
    end

    initial begin
        RESET = 1'b1;
        HSEL = 1'b0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HADDR = 32'h0000_0000;
        HWDATA = 32'h0000_0000;
        REQ_VEC = '0;
        lat = 4'h3;
        s_hit = 1'b0;
        p_hit = 1'b0;
        repeat (2) @(posedge REF_CLK);
        RESET <= 1'b0;
        @(posedge REF_CLK);
        rdc(12'h100, 16'h0000);
        rdc(12'h108, 16'h0F00);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].w);
            rdc(rows[i].a, rows[i].e);
        end
        // one-shot word block of three elements on request line 11, with null writes
        bus(1'b1, 12'h008, 16'h0100);
        bus(1'b1, 12'h010, 16'h0800);
        bus(1'b1, 12'h014, 16'h0002);
        bus(1'b1, 12'h004, 16'h000B);
        bus(1'b1, 12'h000, 16'h8801);
        for (int k = 0; k < 3; k++) begin
            eq.push_back({1'b1, 3'h0, 16'h0100 + 16'(k * 2), 16'h0800, 3'b001});
            REQ_VEC[11] <= 1'b1;
            @(posedge REF_CLK);
            REQ_VEC[11] <= 1'b0;
            wait_x(k + 1);
        end
        chk("block pulses", 39'(1), 39'(irq_n));
        rdc(12'h000, 16'h0801);
        rdc(12'h100, 16'h0104);
        rdc(12'h108, 16'h0000);
        // force on a disabled channel waits; software cannot clear it
        bus(1'b1, 12'h044, 16'h8000);
        repeat (10) @(posedge REF_CLK);
        chk("disabled channel idle", 39'(3), 39'(xq.size()));
        bus(1'b1, 12'h044, 16'h0000);
        rdc(12'h044, 16'h8000);
        bus(1'b1, 12'h048, 16'h0200);
        bus(1'b1, 12'h050, 16'h0900);
        lat <= 4'h0;
        s_hit <= 1'b1;
        p_hit <= 1'b1;
        eq.push_back({1'b1, 3'h2, 16'h0200, 16'h0900, 3'b110});
        bus(1'b1, 12'h040, 16'hE800);
        wait_x(4);
        rdc(12'h044, 16'h0000);
        rdc(12'h104, 16'h0404);
        rdc(12'h108, 16'h0200);
        // continuous ping-pong: two forced blocks alternate buffers
        s_hit <= 1'b0;
        p_hit <= 1'b0;
        lat <= 4'h1;
        bus(1'b1, 12'h088, 16'h0300);
        bus(1'b1, 12'h08C, 16'h0400);
        bus(1'b1, 12'h080, 16'h8002);
        eq.push_back({1'b1, 3'h4, 16'h0300, 16'h0000, 3'b000});
        eq.push_back({1'b1, 3'h4, 16'h0400, 16'h0000, 3'b000});
        bus(1'b1, 12'h084, 16'h8000);
        wait_x(5);
        rdc(12'h108, 16'h0410);
        bus(1'b1, 12'h084, 16'h8000);
        wait_x(6);
        rdc(12'h108, 16'h0400);
        chk("all pulses", 39'(4), 39'(irq_n));
        // byte half-block on channel 6 via line 5, then fixed-address words on channel 5 via line 6
        bus(1'b1, 12'h0C8, 16'h0500);
        bus(1'b1, 12'h0D4, 16'h0003);
        bus(1'b1, 12'h0C4, 16'h0005);
        bus(1'b1, 12'h0C0, 16'hD001);
        bus(1'b1, 12'h0A8, 16'h0600);
        bus(1'b1, 12'h0B4, 16'h0001);
        bus(1'b1, 12'h0A4, 16'h0006);
        bus(1'b1, 12'h0A0, 16'h8011);
        for (int k = 0; k < 6; k++) begin
            if (k < 4) eq.push_back({1'b1, 3'h6, 16'h0500 + 16'(k), 16'h0000, 3'b010});
            else eq.push_back({1'b1, 3'h5, 16'h0600, 16'h0000, 3'b000});
            REQ_VEC[k < 4 ? 5 : 6] <= 1'b1;
            @(posedge REF_CLK);
            REQ_VEC[k < 4 ? 5 : 6] <= 1'b0;
            wait_x(k + 7);
        end
        chk("half and block pulses", 39'(6), 39'(irq_n));
        rdc(12'h0C0, 16'h5001);
        rdc(12'h100, 16'h0600);
        chk("transfer total", 39'(12), 39'(xq.size()));
        foreach (eq[i]) chk($sformatf("transfer %0d", i), eq[i], xq[i]);
        // mid-run reset must bring the status and channel registers back to their reset values
        RESET <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        RESET <= 1'b0;
        @(posedge REF_CLK);
        rdc(12'h100, 16'h0000);
        rdc(12'h108, 16'h0F00);
        rdc(12'h080, 16'h0000);
        results();
    end
endmodule

bind dcs_regs dcs_regs_properties chk_u (.REF_CLK(REF_CLK), .RESET(RESET), .HSEL(HSEL), .HTRANS(HTRANS),
    .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .XFER_DONE(XFER_DONE),
    .XFER(XFER), .CH_IRQ(CH_IRQ));
